/* File: design/sfa_pkg.sv */
// shared constants and types for the subtract family datapath
`default_nettype none
package sfa_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_AW = 8;
  localparam int unsigned IMM_W  = 8;

  // opcode pairs, upper seven opcode bits; bit 0 is the immediate select
  localparam logic [6:0] OPP_SUB_CARRY_SIGNED_TRAP   = 7'h14;
  localparam logic [6:0] OPP_SUB_CARRY_UNSIGNED_TRAP = 7'h15;
  localparam logic [6:0] OPP_REVERSE_SUBTRACT        = 7'h1A;
  localparam logic [6:0] OPP_REVERSE_SUBTRACT_CARRY  = 7'h1E;
  localparam int unsigned IMM_SEL_BIT = 0;

  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [DATA_W-IMM_W-1:0] IMM_PAD = 24'h00_0000;

  typedef struct packed {
    logic [7:0]        opcode;
    logic [REG_AW-1:0] destination_field;
    logic [REG_AW-1:0] first_source_field;
    logic [REG_AW-1:0] second_source_field;
  } sfa_instr_type;

  typedef enum logic [2:0] {
    SFA_NONE = 3'b000,
    SFA_SCS  = 3'b001,
    SFA_SCU  = 3'b010,
    SFA_SR   = 3'b011,
    SFA_SRC  = 3'b100
  } sfa_kind_type;

  typedef struct packed {
    logic v;
    logic n;
    logic z;
    logic c;
  } sfa_flags_type;

  localparam sfa_flags_type FLAGS_RESET = 4'h0;

  typedef struct packed {
    logic              en;
    logic [REG_AW-1:0] addr;
    logic [DATA_W-1:0] data;
  } sfa_wb_type;

  localparam sfa_wb_type WB_RESET = 41'h000_0000_0000;

endpackage : sfa_pkg
`default_nettype wire

/* File: design/sfa_adder.sv */
// 32-bit adder with carry out and signed overflow
`timescale 1ns/100ps
`default_nettype none
module sfa_adder (
  input  wire logic [sfa_pkg::DATA_W-1:0] x,
  input  wire logic [sfa_pkg::DATA_W-1:0] y,
  input  wire logic                       cin,
  output logic      [sfa_pkg::DATA_W-1:0] sum,
  output logic                            cout,
  output logic                            ovf
);

  logic [sfa_pkg::DATA_W:0] full;

  always_comb
  begin
    full = {1'b0, x} + {1'b0, y} + {{sfa_pkg::DATA_W{1'b0}}, cin};
    sum  = full[sfa_pkg::DATA_W-1:0];
    cout = full[sfa_pkg::DATA_W];
    ovf  = (x[sfa_pkg::DATA_W-1] == y[sfa_pkg::DATA_W-1]) &&
           (sum[sfa_pkg::DATA_W-1] != x[sfa_pkg::DATA_W-1]);
  end

endmodule : sfa_adder
`default_nettype wire

/* File: design/sfa_subtract_alu.sv */
// subtract family datapath: decode, operand fetch, add, write-back, flags, trap
//
// What this block does
// - carry subtracts with traps compute first plus inverted second plus carry.
// - signed carry subtract traps on two's-complement overflow.
// - unsigned carry subtract traps on unsigned underflow, i.e. no carry out.
// - signed carry subtract writes its destination even when trapping.
// - unsigned carry subtract writes its destination even when trapping.
// - reverse subtract computes second minus first, never traps.
// - reverse subtract with carry computes second plus inverted first plus carry.
// - immediate bit picks zero-extended 8-bit immediate, else second source register.
`timescale 1ns/100ps
`default_nettype none
module sfa_subtract_alu (
  input  wire logic                          clk,
  input  wire logic                          nrst,
  input  wire logic                          instr_valid,
  input  wire sfa_pkg::sfa_instr_type        instr,
  output logic      [sfa_pkg::REG_AW-1:0]    rd_addr_a,
  input  wire logic [sfa_pkg::DATA_W-1:0]    rd_data_a,
  output logic      [sfa_pkg::REG_AW-1:0]    rd_addr_b,
  input  wire logic [sfa_pkg::DATA_W-1:0]    rd_data_b,
  output sfa_pkg::sfa_wb_type                wb,
  output sfa_pkg::sfa_flags_type             flags,
  output logic                               flags_we,
  output logic                               trap_out_of_range,
  input  wire logic                          flags_load,
  input  wire sfa_pkg::sfa_flags_type        flags_load_value
);

  ////////////////////////////////////////////////////////////////////////////
  // stage 1: instruction register

  logic                   valid_q;
  logic                   valid_d;
  sfa_pkg::sfa_instr_type instr_q;
  sfa_pkg::sfa_instr_type instr_d;

  always_comb
  begin
    valid_d = instr_valid;
    instr_d = instr_valid ? instr : instr_q;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      valid_q <= 1'b0;
      instr_q <= '0;
    end
    else
    begin
      valid_q <= valid_d;
      instr_q <= instr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode and operand fetch

  sfa_pkg::sfa_kind_type       kind;
  logic                        imm_sel;
  logic                        active;
  logic [sfa_pkg::DATA_W-1:0]  first_source;
  logic [sfa_pkg::DATA_W-1:0]  reg_b;
  logic [sfa_pkg::DATA_W-1:0]  second_source;
  sfa_pkg::sfa_wb_type         wb_q;
  sfa_pkg::sfa_wb_type         wb_d;
  sfa_pkg::sfa_flags_type      flags_q;
  sfa_pkg::sfa_flags_type      flags_d;
  logic                        flags_we_q;
  logic                        flags_we_d;
  logic                        trap_q;
  logic                        trap_d;

  always_comb
  begin
    // low opcode bit ignored so both members of a pair land together
    unique case (instr_q.opcode[7:1])
      sfa_pkg::OPP_SUB_CARRY_SIGNED_TRAP:   kind = sfa_pkg::SFA_SCS;
      sfa_pkg::OPP_SUB_CARRY_UNSIGNED_TRAP: kind = sfa_pkg::SFA_SCU;
      sfa_pkg::OPP_REVERSE_SUBTRACT:        kind = sfa_pkg::SFA_SR;
      sfa_pkg::OPP_REVERSE_SUBTRACT_CARRY:  kind = sfa_pkg::SFA_SRC;
      default:                              kind = sfa_pkg::SFA_NONE;
    endcase
    imm_sel = instr_q.opcode[sfa_pkg::IMM_SEL_BIT];
    active  = valid_q && (kind != sfa_pkg::SFA_NONE);
  end

  assign rd_addr_a = instr_q.first_source_field;
  assign rd_addr_b = instr_q.second_source_field;

  // the file write lands one cycle late, so bypass the result still in flight
  always_comb
  begin
    first_source = (wb_q.en && wb_q.addr == instr_q.first_source_field)
                   ? wb_q.data : rd_data_a;
    reg_b        = (wb_q.en && wb_q.addr == instr_q.second_source_field)
                   ? wb_q.data : rd_data_b;
    second_source = imm_sel ? {sfa_pkg::IMM_PAD, instr_q.second_source_field}
                            : reg_b;
  end

  ////////////////////////////////////////////////////////////////////////////
  // operand steering into the adder

  logic [sfa_pkg::DATA_W-1:0] add_x;
  logic [sfa_pkg::DATA_W-1:0] add_y;
  logic                       add_cin;
  logic [sfa_pkg::DATA_W-1:0] add_sum;
  logic                       add_cout;
  logic                       add_ovf;

  always_comb
  begin
    unique case (kind)
      sfa_pkg::SFA_SR:
      begin
        add_x   = second_source;
        add_y   = ~first_source;
        add_cin = 1'b1;
      end
      sfa_pkg::SFA_SRC:
      begin
        add_x   = second_source;
        add_y   = ~first_source;
        add_cin = flags_q.c;
      end
      default:
      begin
        add_x   = first_source;
        add_y   = ~second_source;
        add_cin = flags_q.c;
      end
    endcase
  end

  sfa_adder u_adder (
    .x    (add_x),
    .y    (add_y),
    .cin  (add_cin),
    .sum  (add_sum),
    .cout (add_cout),
    .ovf  (add_ovf)
  );

  ////////////////////////////////////////////////////////////////////////////
  // stage 2: write-back, flags, trap

  always_comb
  begin
    wb_d.en    = active;
    wb_d.addr  = instr_q.destination_field;
    wb_d.data  = active ? add_sum : wb_q.data;
    flags_we_d = active;
    trap_d     = 1'b0;
    if (active && kind == sfa_pkg::SFA_SCS)
      trap_d = add_ovf;
    if (active && kind == sfa_pkg::SFA_SCU)
      trap_d = ~add_cout;
    flags_d = flags_q;
    // own result outranks an outside load landing in the same cycle
    if (active)
    begin
      flags_d.v = add_ovf;
      flags_d.n = add_sum[sfa_pkg::DATA_W-1];
      flags_d.z = (add_sum == sfa_pkg::ZERO_WORD);
      flags_d.c = add_cout;
    end
    else if (flags_load)
      flags_d = flags_load_value;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wb_q       <= sfa_pkg::WB_RESET;
      flags_q    <= sfa_pkg::FLAGS_RESET;
      flags_we_q <= 1'b0;
      trap_q     <= 1'b0;
    end
    else
    begin
      wb_q       <= wb_d;
      flags_q    <= flags_d;
      flags_we_q <= flags_we_d;
      trap_q     <= trap_d;
    end
  end

  assign wb                = wb_q;
  assign flags             = flags_q;
  assign flags_we          = flags_we_q;
  assign trap_out_of_range = trap_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [sfa_pkg::DATA_W+1:0] chk_sdiff;
  logic                       chk_sovf;
  logic                       chk_under;

  always_comb
  begin
    chk_sdiff = {{2{first_source[sfa_pkg::DATA_W-1]}}, first_source}
              - {{2{second_source[sfa_pkg::DATA_W-1]}}, second_source}
              - 34'h0_0000_0001 + {33'h0_0000_0000, flags_q.c};
    chk_sovf  = (chk_sdiff[sfa_pkg::DATA_W+1:sfa_pkg::DATA_W-1] != 3'h0) &&
                (chk_sdiff[sfa_pkg::DATA_W+1:sfa_pkg::DATA_W-1] != 3'h7);
    chk_under = ({1'b0, first_source} + {32'h0000_0000, flags_q.c}) <
                ({1'b0, second_source} + 33'h0_0000_0001);
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_carry_sub_result;
    active && (kind == sfa_pkg::SFA_SCS || kind == sfa_pkg::SFA_SCU) |=>
      wb_q.data == $past(first_source - second_source - 32'h1 + {31'h0, flags_q.c});
  endproperty
  a_carry_sub_result: assert property (p_carry_sub_result)
    else $error("carry subtract result wrong");

  property p_signed_trap;
    active && kind == sfa_pkg::SFA_SCS |=> trap_q == $past(chk_sovf);
  endproperty
  a_signed_trap: assert property (p_signed_trap)
    else $error("signed overflow trap wrong");

  property p_unsigned_trap;
    active && kind == sfa_pkg::SFA_SCU |=> trap_q == $past(chk_under);
  endproperty
  a_unsigned_trap: assert property (p_unsigned_trap)
    else $error("unsigned underflow trap wrong");

  property p_signed_write;
    active && kind == sfa_pkg::SFA_SCS && chk_sovf |=> wb_q.en && trap_q;
  endproperty
  a_signed_write: assert property (p_signed_write)
    else $error("trapping signed subtract lost its write");

  property p_unsigned_write;
    active && kind == sfa_pkg::SFA_SCU && chk_under |=> wb_q.en && trap_q;
  endproperty
  a_unsigned_write: assert property (p_unsigned_write)
    else $error("trapping unsigned subtract lost its write");

  property p_reverse;
    active && kind == sfa_pkg::SFA_SR |=>
      !trap_q && wb_q.data == $past(second_source - first_source);
  endproperty
  a_reverse: assert property (p_reverse)
    else $error("reverse subtract wrong");

  property p_reverse_carry;
    active && kind == sfa_pkg::SFA_SRC |=> !trap_q &&
      wb_q.data == $past(second_source - first_source - 32'h1 + {31'h0, flags_q.c});
  endproperty
  a_reverse_carry: assert property (p_reverse_carry)
    else $error("reverse subtract with carry wrong");

  property p_fields;
    instr_valid ##1 active |-> rd_addr_a == $past(instr.first_source_field)
      ##1 wb_q.addr == $past(instr.destination_field, 2);
  endproperty
  a_fields: assert property (p_fields)
    else $error("register field routing wrong");

  property p_immediate;
    valid_q && imm_sel |->
      second_source[sfa_pkg::DATA_W-1:sfa_pkg::IMM_W] == sfa_pkg::IMM_PAD
      && second_source[sfa_pkg::IMM_W-1:0] == instr_q.second_source_field;
  endproperty
  a_immediate: assert property (p_immediate)
    else $error("immediate not zero-extended");

  property p_flags;
    active |=> flags_we_q && wb_q.en && flags_q.z == (wb_q.data == sfa_pkg::ZERO_WORD)
      && flags_q.n == wb_q.data[sfa_pkg::DATA_W-1];
  endproperty
  a_flags: assert property (p_flags)
    else $error("status flags not updated");

  property p_pair;
    valid_q && instr_q.opcode[7:1] == sfa_pkg::OPP_REVERSE_SUBTRACT |->
      kind == sfa_pkg::SFA_SR;
  endproperty
  a_pair: assert property (p_pair)
    else $error("opcode pair decoded apart");

  c_signed_trap:   cover property (active && kind == sfa_pkg::SFA_SCS ##1 trap_q);
  c_unsigned_trap: cover property (active && kind == sfa_pkg::SFA_SCU ##1 trap_q);
  c_reverse_imm:   cover property (active && kind == sfa_pkg::SFA_SR && imm_sel);
  c_bypass:        cover property (active && wb_q.en &&
                                   wb_q.addr == instr_q.first_source_field);

endmodule : sfa_subtract_alu
`default_nettype wire

/* File: bench/sfa_regfile_model.sv */
// register file model on the far side of the subtract datapath
`timescale 1ns/100ps
`default_nettype none
module sfa_regfile_model (
  input  wire logic                       clk,
  input  wire logic [sfa_pkg::REG_AW-1:0] rd_addr_a,
  output logic      [sfa_pkg::DATA_W-1:0] rd_data_a,
  input  wire logic [sfa_pkg::REG_AW-1:0] rd_addr_b,
  output logic      [sfa_pkg::DATA_W-1:0] rd_data_b,
  input  wire sfa_pkg::sfa_wb_type        wb
);
  logic [sfa_pkg::DATA_W-1:0] mem [256];
  // same seed pattern as the bench model, so both start alike
  initial
  begin
    for (int i = 0; i < 256; i++) mem[i] = 32'(i) * 32'h0F1E_2D3D;
  end
  assign rd_data_a = mem[rd_addr_a];
  assign rd_data_b = mem[rd_addr_b];
  always @(posedge clk)
  begin
    if (wb.en === 1'b1) mem[wb.addr] <= wb.data;
  end
endmodule : sfa_regfile_model
`default_nettype wire

/* File: bench/tb_subtract_family_alu.sv */
// self-checking bench for the subtract family datapath
`timescale 1ns/100ps
`default_nettype none
module tb_subtract_family_alu;
  typedef struct packed {
    logic                   chk;
    logic                   en;
    logic [7:0]             addr;
    logic [31:0]            data;
    logic                   trap;
    sfa_pkg::sfa_flags_type fl;
  } sfa_slot_type;
  logic                   clk = 1'b0;
  logic                   nrst = 1'b0;
  logic                   instr_valid = 1'b0;
  sfa_pkg::sfa_instr_type instr = '0;
  logic                   flags_load = 1'b0;
  sfa_pkg::sfa_flags_type flags_load_value = '0;
  logic [7:0]             rd_addr_a;
  logic [7:0]             rd_addr_b;
  logic [31:0]            rd_data_a;
  logic [31:0]            rd_data_b;
  sfa_pkg::sfa_wb_type    wb;
  sfa_pkg::sfa_flags_type flags;
  logic                   flags_we;
  logic                   trap_out_of_range;
  int                     mismatches = 0;
  int                     samples_checked = 0;
  int                     cycles = 0;
  int                     seed = 53;
  logic [31:0]            mreg [256];
  sfa_pkg::sfa_flags_type mfl = '0;
  sfa_slot_type           p1 = '0;
  sfa_slot_type           p2 = '0;
  logic [7:0]             ops [8] = '{8'h28, 8'h29, 8'h2A, 8'h2B, 8'h34, 8'h35, 8'h3C, 8'h3D};
  sfa_pkg::sfa_instr_type ri;
  ////////////////////////////////////////////////////////////////////////////////////////
  sfa_subtract_alu u_dut (
    .clk(clk), .nrst(nrst), .instr_valid(instr_valid), .instr(instr),
    .rd_addr_a(rd_addr_a), .rd_data_a(rd_data_a), .rd_addr_b(rd_addr_b),
    .rd_data_b(rd_data_b), .wb(wb), .flags(flags), .flags_we(flags_we),
    .trap_out_of_range(trap_out_of_range), .flags_load(flags_load),
    .flags_load_value(flags_load_value)
  );
  sfa_regfile_model u_rf (
    .clk(clk), .rd_addr_a(rd_addr_a), .rd_data_a(rd_data_a),
    .rd_addr_b(rd_addr_b), .rd_data_b(rd_data_b), .wb(wb)
  );
  always #20 clk = ~clk;
  // ceiling well above the roughly 1050 cycles the sequence needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      mismatches++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // one cycle: check the slot issued two cycles ago, then drive and model this one
  task automatic step(input logic v, input sfa_pkg::sfa_instr_type in, input logic ld);
    logic [32:0]  s;
    logic [31:0]  a;
    logic [31:0]  b;
    logic [31:0]  x;
    logic [31:0]  y;
    logic         ci;
    sfa_slot_type e;
    @(negedge clk);
    check("wb_en", wb.en, p2.en);
    check("trap", trap_out_of_range, p2.trap);
    check("flags_we", flags_we, p2.en);
    if (p2.chk) check("flags", flags, p2.fl);
    if (p2.en) check("wb_addr", wb.addr, p2.addr);
    if (p2.en) check("wb_data", wb.data, p2.data);
    p2 = p1;
    instr_valid = v;
    instr = in;
    flags_load = ld;
    flags_load_value = 4'($random(seed));
    // an outside load is ignored while the previous subtract is computing
    if (ld && !p1.en) mfl = flags_load_value;
    e = '0;
    e.chk = v;
    e.en = v;
    a = mreg[in.first_source_field];
    b = in.opcode[0] ? {24'h00_0000, in.second_source_field} : mreg[in.second_source_field];
    x = a;
    y = ~b;
    ci = mfl.c;
    case (in.opcode[7:1])
      7'h14, 7'h15: ;
      7'h1A: begin x = b; y = ~a; ci = 1'b1; end
      7'h1E: begin x = b; y = ~a; end
      default: e.en = 1'b0;
    endcase
    s = {1'b0, x} + {1'b0, y} + 33'(ci);
    if (e.en)
    begin
      mfl = {(x[31] == y[31]) && (s[31] != x[31]), s[31], s[31:0] == 32'h0000_0000, s[32]};
      mreg[in.destination_field] = s[31:0];
      e.trap = (in.opcode[7:1] == 7'h14) ? mfl.v : (in.opcode[7:1] == 7'h15) && !s[32];
    end
    e.addr = in.destination_field;
    e.data = s[31:0];
    e.fl = mfl;
    p1 = e;
  endtask : step
  ////////////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    for (int i = 0; i < 256; i++) mreg[i] = 32'(i) * 32'h0F1E_2D3D;
    repeat (12) @(posedge clk);
    @(negedge clk);
    check("rst_wb_en", wb.en, 1'b0);
    check("rst_flags", flags, 4'h0);
    nrst = 1'b1;
    for (int k = 0; k < 500; k++)
    begin
      ri = 32'($random(seed));
      ri.opcode = (k % 8 == 7) ? 8'($random(seed)) : ops[(k < 16) ? k / 2 : {$random(seed)} % 8];
      ri.destination_field &= 8'h0F;
      ri.first_source_field &= 8'h0F;
      if (!ri.opcode[0]) ri.second_source_field &= 8'h0F;
      // short register range forces result forwarding between back-to-back ops
      if (k < 16 || $random(seed) % 2)
      begin
        step(1'b0, ri, 1'b0);
        step(1'b0, ri, 1'b1);
      end
      step(1'b1, ri, 1'b0);
    end
    repeat (3) step(1'b0, ri, 1'b0);
    nrst = 1'b0;
    @(negedge clk);
    check("rst2_flags", flags, 4'h0);
    check("rst2_wb_en", wb.en, 1'b0);
    mfl = '0;
    p1 = '0;
    p2 = '0;
    nrst = 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      ri.opcode = ops[k];
      step(1'b1, ri, 1'($random(seed)));
    end
    repeat (3) step(1'b0, ri, 1'b0);
    test_done();
  end
endmodule : tb_subtract_family_alu
`default_nettype wire
